// ---- lf_rx_pkg.sv ----
package lf_rx_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_PAGE          = 8'h00;
    localparam logic [7:0] OFS_DEQ_GAIN      = 8'h04;
    localparam logic [7:0] OFS_SLICER_FILTER = 8'h08;
    localparam logic [7:0] OFS_CARRIER_COUNT = 8'h0C;
    localparam logic [7:0] OFS_STATUS        = 8'h10;
    localparam logic [7:0] OFS_MODE          = 8'h14;

    // Field positions
    localparam int PAGE_BIT     = 0;
    localparam int GAIN_LSB     = 6;
    localparam int FINAL_LSB    = 4;
    localparam int DATA_AUTOZERO_ENABLE_BIT     = 3;
    localparam int DEQR_LSB     = 1;
    localparam int DEQ_ENABLE_BIT    = 0;
    localparam int SLICER_HYSTERESIS_LSB     = 6;
    localparam int AFMODE_BIT   = 5;
    localparam int AFOFS_BIT    = 4;
    localparam int POL_BIT      = 3;
    localparam int AZCNT_LSB    = 0;
    localparam int CC_LSB       = 0;
    localparam int FLAG_BIT     = 0;
    localparam int CNT_LSB      = 8;
    localparam int TOG_BIT      = 0;
    localparam int AZTRIG_LSB   = 1;

    // Field widths
    localparam int CC_W         = 4;
    localparam int AZCNT_W      = 3;
    localparam int CNT_W        = 5;

    // Reset values
    localparam logic [7:0] RST_PAGE          = 8'h00;
    localparam logic [7:0] RST_DEQ_GAIN      = 8'h00;
    localparam logic [7:0] RST_SLICER_FILTER = 8'h00;
    localparam logic [7:0] RST_CARRIER_COUNT = 8'h00;
    localparam logic [7:0] RST_MODE          = 8'h00;

    // Upper nibble of the carrier count register is never writable
    localparam logic [7:0] CARRIER_COUNT_MASK = 8'h0F;

    // Auto-zero trigger control codes
    localparam logic [1:0] AZ_TRIG_EDGES  = 2'h0;
    localparam logic [1:0] AZ_TRIG_RANDOM = 2'h1;
    localparam logic [1:0] AZ_TRIG_LOW    = 2'h2;
    localparam logic [1:0] AZ_TRIG_HIGH   = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_READ_FETCH
    } bus_state_t;

    typedef struct packed {
        logic [1:0] third_amp_gain;
        logic [1:0] final_stage_select;
        logic       data_autozero_enable;
        logic [1:0] deq_resistor_select;
        logic       deq_enable;
    } frontend_cfg_t;

    typedef struct packed {
        logic [1:0] slicer_hysteresis;
        logic       average_filter_mode;
        logic       average_filter_offset;
        logic       manchester_polarity;
        logic [2:0] autozero_edge_count;
    } decoder_cfg_t;

endpackage : lf_rx_pkg

// ---- carrier_validation_counter.sv ----
`timescale 1ns/10ps
module carrier_validation_counter (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_n_in,
    // Sample stream
    input  wire logic                         sample_valid_in,
    input  wire logic                         carrier_seen_in,
    // Hold conditions
    input  wire logic                         data_mode_in,
    input  wire logic                         toggle_mode_in,
    // Configuration and clear
    input  wire logic [lf_rx_pkg::CC_W-1:0]   valid_count_in,
    input  wire logic                         flag_clear_in,
    // Results
    output logic                              carrier_detect_flag_out,
    output logic                              chain_start_out,
    output logic [lf_rx_pkg::CNT_W-1:0]       count_out
);

    logic                          hold;
    logic                          hit;
    logic [lf_rx_pkg::CNT_W-1:0]   target;

    assign hold   = data_mode_in | toggle_mode_in;   // R14 R16
    assign hit    = sample_valid_in & carrier_seen_in & ~hold;
    assign target = {1'b0, valid_count_in};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= '0;
        end else if (hold) begin
            count_out <= '0;   // R14 R16
        end else if (sample_valid_in) begin
            if (!carrier_seen_in) begin
                count_out <= '0;   // R13
            end else if (count_out <= target) begin
                count_out <= count_out + 5'h01;   // R13
            end
        end
    end

    // Set beats a same-cycle clear so no detection is lost
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            carrier_detect_flag_out <= 1'b0;
        end else if (hit && count_out == target) begin
            carrier_detect_flag_out <= 1'b1;   // R12
        end else if (flag_clear_in) begin
            carrier_detect_flag_out <= 1'b0;   // R19
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chain_start_out <= 1'b0;
        end else begin
            chain_start_out <= hit && count_out == '0;   // R15
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_hold_clears_count: assert property (hold |=> count_out == '0) // R14
        else $error("count not cleared while held");
    a_miss_resets_count: assert property (
        sample_valid_in && !carrier_seen_in |=> count_out == '0) // R13
        else $error("missed sample did not reset count");
    a_flag_on_target: assert property (
        hit && count_out == target |=> carrier_detect_flag_out) // R12
        else $error("flag not raised at target count");
    a_flag_stays_set: assert property (
        carrier_detect_flag_out && !flag_clear_in |=> carrier_detect_flag_out) // R19
        else $error("flag dropped without clear");
    a_first_hit_start: assert property (
        hit && count_out == '0 |=> chain_start_out ##1 !chain_start_out) // R15
        else $error("chain start not a single pulse on first hit");

endmodule : carrier_validation_counter

// ---- lf_receiver_control_regs.sv ----
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// R1: Three registers reachable only with page bit
// R2: Bits 7-6 select third amplifier gain
// R3: Bits 5-4 select log amplifier final stage
// R4: Bit 3 permits auto-zero during data
// R5: Bits 2-1 select de-Q resistor
// R6: Bit 0 enables de-Q system
// R7: Bits 7-6 select slicer hysteresis
// R8: Bits 5-4 select averaging filter mode
// R9: Bit 3 selects Manchester edge polarity
// R10: Polarity resets clear, ignored in carrier mode
// R11: Bits 2-0 set edges between auto-zeros
// R12: Flag rises at validation count plus one
// R13: Count runs on consecutive hits, misses clear
// R14: Counter held in reset during data mode
// R15: First validation starts the receiver chain
// R16: Counter disabled while toggle mode set
// R17: Carrier register upper nibble reserved, not writable
// R18: Auto-zero starts after programmed data edges
// R19: Flag stays set until software clears
module lf_receiver_control_regs (
    // Clock and reset
    input  wire logic                      sys_clk_in,
    input  wire logic                      resetn_in,
    // AHB-Lite slave
    input  wire logic                      hsel_in,
    input  wire logic [31:0]               haddr_in,
    input  wire logic [1:0]                htrans_in,
    input  wire logic                      hwrite_in,
    input  wire logic [2:0]                hsize_in,
    input  wire logic [31:0]               hwdata_in,
    input  wire logic                      hready_in,
    output logic [31:0]                    hrdata_out,
    output logic                           hreadyout_out,
    output logic                           hresp_out,
    // Receiver status inputs
    input  wire logic                      data_mode_in,
    input  wire logic                      sample_valid_in,
    input  wire logic                      carrier_seen_in,
    input  wire logic                      data_edge_in,
    input  wire logic                      data_level_in,
    // Configuration to the analog front end and decoder
    output lf_rx_pkg::frontend_cfg_t       frontend_cfg_out,
    output lf_rx_pkg::decoder_cfg_t        decoder_cfg_out,
    // Events to the receiver chain
    output logic                           carrier_detect_flag_out,
    output logic                           chain_start_out,
    output logic                           autozero_req_out
);

    logic                          rst_sync1_r;
    logic                          rst_n;
    lf_rx_pkg::bus_state_t         bus_state_r;
    logic                          wr_pend_r;
    logic [7:0]                    wr_addr_r;
    logic [7:0]                    rd_addr_r;
    logic [7:0]                    page_r;
    logic [7:0]                    deq_gain_control_r;
    logic [7:0]                    slicer_filter_control_r;
    logic [7:0]                    carrier_count_control_r;
    logic [7:0]                    mode_r;
    logic [2:0]                    az_edges_r;
    logic [2:0]                    az_edges_nxt;
    logic                          az_fire;
    logic                          az_cond;
    logic                          page_on;
    logic                          addr_take;
    logic                          wr_now;
    logic                          flag_clear;
    logic [31:0]                   rd_val;
    logic [7:0]                    wr_byte;
    logic                          flag;
    logic                          chain_start;
    logic [lf_rx_pkg::CNT_W-1:0]   carrier_count;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync1_r <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_n       <= rst_sync1_r;
        end
    end

    assign page_on    = page_r[lf_rx_pkg::PAGE_BIT];
    assign addr_take  = hsel_in && hready_in && htrans_in == lf_rx_pkg::HTRANS_NONSEQ;
    assign wr_now     = wr_pend_r;
    assign wr_byte    = hwdata_in[7:0];
    assign flag_clear = wr_now && wr_addr_r == lf_rx_pkg::OFS_STATUS
                        && hwdata_in[lf_rx_pkg::FLAG_BIT];

    // Bus sequencing: writes complete with no wait, reads take one wait
    // state so a write in the preceding data phase is already visible.
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_r   <= lf_rx_pkg::BUS_IDLE;
            wr_pend_r     <= 1'b0;
            wr_addr_r     <= 8'h00;
            rd_addr_r     <= 8'h00;
            hreadyout_out <= 1'b1;
        end else begin
            case (bus_state_r)
                lf_rx_pkg::BUS_IDLE: begin
                    wr_pend_r <= addr_take && hwrite_in;
                    if (addr_take) begin
                        wr_addr_r <= haddr_in[7:0];
                        rd_addr_r <= haddr_in[7:0];
                    end
                    if (addr_take && !hwrite_in) begin
                        bus_state_r   <= lf_rx_pkg::BUS_READ_FETCH;
                        hreadyout_out <= 1'b0;
                    end
                end
                lf_rx_pkg::BUS_READ_FETCH: begin
                    wr_pend_r     <= 1'b0;
                    bus_state_r   <= lf_rx_pkg::BUS_IDLE;
                    hreadyout_out <= 1'b1;
                end
                default: begin
                    bus_state_r   <= lf_rx_pkg::BUS_IDLE;
                    hreadyout_out <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
        end
    end

    // Read mux; paged registers read zero while the page is closed
    always_comb begin
        rd_val = 32'h0000_0000;
        if (rd_addr_r == lf_rx_pkg::OFS_PAGE) begin
            rd_val[7:0] = page_r;
        end else if (rd_addr_r == lf_rx_pkg::OFS_DEQ_GAIN && page_on) begin   // R1
            rd_val[7:0] = deq_gain_control_r;
        end else if (rd_addr_r == lf_rx_pkg::OFS_SLICER_FILTER && page_on) begin   // R1
            rd_val[7:0] = slicer_filter_control_r;
        end else if (rd_addr_r == lf_rx_pkg::OFS_CARRIER_COUNT && page_on) begin   // R1
            rd_val[7:0] = carrier_count_control_r & lf_rx_pkg::CARRIER_COUNT_MASK;   // R17
        end else if (rd_addr_r == lf_rx_pkg::OFS_STATUS) begin
            rd_val[lf_rx_pkg::FLAG_BIT] = flag;
            rd_val[lf_rx_pkg::CNT_LSB +: lf_rx_pkg::CNT_W] = carrier_count;
        end else if (rd_addr_r == lf_rx_pkg::OFS_MODE) begin
            rd_val[7:0] = mode_r;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_out <= 32'h0000_0000;
        end else if (bus_state_r == lf_rx_pkg::BUS_READ_FETCH) begin
            hrdata_out <= rd_val;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            page_r <= lf_rx_pkg::RST_PAGE;
        end else if (wr_now && wr_addr_r == lf_rx_pkg::OFS_PAGE) begin
            page_r <= {7'h00, wr_byte[lf_rx_pkg::PAGE_BIT]};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            deq_gain_control_r <= lf_rx_pkg::RST_DEQ_GAIN;
        end else if (wr_now && wr_addr_r == lf_rx_pkg::OFS_DEQ_GAIN && page_on) begin   // R1
            deq_gain_control_r <= wr_byte;
        end
    end

    // Polarity bit comes back clear on reset
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            slicer_filter_control_r <= lf_rx_pkg::RST_SLICER_FILTER;   // R10
        end else if (wr_now && wr_addr_r == lf_rx_pkg::OFS_SLICER_FILTER && page_on) begin   // R1
            slicer_filter_control_r <= wr_byte;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            carrier_count_control_r <= lf_rx_pkg::RST_CARRIER_COUNT;
        end else if (wr_now && wr_addr_r == lf_rx_pkg::OFS_CARRIER_COUNT && page_on) begin   // R1
            carrier_count_control_r <= wr_byte & lf_rx_pkg::CARRIER_COUNT_MASK;   // R17
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= lf_rx_pkg::RST_MODE;
        end else if (wr_now && wr_addr_r == lf_rx_pkg::OFS_MODE) begin
            mode_r <= {5'h00, wr_byte[2:0]};
        end
    end

    // Field decode to the analog front end
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            frontend_cfg_out <= '0;
        end else begin
            frontend_cfg_out.third_amp_gain       <= deq_gain_control_r[lf_rx_pkg::GAIN_LSB +: 2];  // R2
            frontend_cfg_out.final_stage_select   <= deq_gain_control_r[lf_rx_pkg::FINAL_LSB +: 2]; // R3
            frontend_cfg_out.data_autozero_enable <= deq_gain_control_r[lf_rx_pkg::DATA_AUTOZERO_ENABLE_BIT];       // R4
            frontend_cfg_out.deq_resistor_select  <= deq_gain_control_r[lf_rx_pkg::DEQR_LSB +: 2];  // R5
            frontend_cfg_out.deq_enable           <= deq_gain_control_r[lf_rx_pkg::DEQ_ENABLE_BIT];      // R6
        end
    end

    // Decoder sees polarity only in data mode; carrier mode forces it low
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            decoder_cfg_out <= '0;
        end else begin
            decoder_cfg_out.slicer_hysteresis     <= slicer_filter_control_r[lf_rx_pkg::SLICER_HYSTERESIS_LSB +: 2]; // R7
            decoder_cfg_out.average_filter_mode   <= slicer_filter_control_r[lf_rx_pkg::AFMODE_BIT];    // R8
            decoder_cfg_out.average_filter_offset <= slicer_filter_control_r[lf_rx_pkg::AFOFS_BIT];     // R8
            decoder_cfg_out.manchester_polarity   <=
                slicer_filter_control_r[lf_rx_pkg::POL_BIT] & data_mode_in;   // R9 R10
            decoder_cfg_out.autozero_edge_count   <=
                slicer_filter_control_r[lf_rx_pkg::AZCNT_LSB +: lf_rx_pkg::AZCNT_W];   // R11
        end
    end

    // Auto-zero pacing. The random trigger code is served like plain edge
    // counting: no random source exists in this block.
    always_comb begin
        case (mode_r[lf_rx_pkg::AZTRIG_LSB +: 2])
            lf_rx_pkg::AZ_TRIG_LOW:  az_cond = !data_level_in;
            lf_rx_pkg::AZ_TRIG_HIGH: az_cond = data_level_in;
            default:                 az_cond = 1'b1;
        endcase
    end

    assign az_fire = data_mode_in && deq_gain_control_r[lf_rx_pkg::DATA_AUTOZERO_ENABLE_BIT]       // R4
                     && az_edges_r >= slicer_filter_control_r[lf_rx_pkg::AZCNT_LSB +: 3] // R18
                     && az_cond;

    always_comb begin
        az_edges_nxt = az_edges_r;
        if (!data_mode_in || !deq_gain_control_r[lf_rx_pkg::DATA_AUTOZERO_ENABLE_BIT] || az_fire) begin
            az_edges_nxt = 3'h0;
        end else if (data_edge_in && az_edges_r != 3'h7) begin
            az_edges_nxt = az_edges_r + 3'h1;   // R11
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            az_edges_r       <= 3'h0;
            autozero_req_out <= 1'b0;
        end else begin
            az_edges_r       <= az_edges_nxt;
            autozero_req_out <= az_fire;   // R18
        end
    end

    carrier_validation_counter u_carrier_validation (
        .clk_in                  (sys_clk_in),
        .rst_n_in                (rst_n),
        .sample_valid_in         (sample_valid_in),
        .carrier_seen_in         (carrier_seen_in),
        .data_mode_in            (data_mode_in),
        .toggle_mode_in          (mode_r[lf_rx_pkg::TOG_BIT]),
        .valid_count_in          (carrier_count_control_r[lf_rx_pkg::CC_LSB +: lf_rx_pkg::CC_W]),
        .flag_clear_in           (flag_clear),
        .carrier_detect_flag_out (flag),
        .chain_start_out         (chain_start),
        .count_out               (carrier_count)
    );

    // Re-register so top outputs come straight from flops
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            carrier_detect_flag_out <= 1'b0;
            chain_start_out         <= 1'b0;
        end else begin
            carrier_detect_flag_out <= flag;          // R12
            chain_start_out         <= chain_start;   // R15
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_read_addr;
        addr_take && !hwrite_in && bus_state_r == lf_rx_pkg::BUS_IDLE;
    endsequence

    sequence s_read_data;
        !hreadyout_out ##1 hreadyout_out;
    endsequence

    a_read_one_wait: assert property (s_read_addr |=> s_read_data)
        else $error("read did not finish after one wait state");
    a_page_closed_hold: assert property ( // R1
        wr_now && !page_on && wr_addr_r == lf_rx_pkg::OFS_DEQ_GAIN
        |=> $stable(deq_gain_control_r))
        else $error("paged register written with page closed");
    a_page_closed_read: assert property ( // R1
        bus_state_r == lf_rx_pkg::BUS_READ_FETCH && !page_on
        && rd_addr_r == lf_rx_pkg::OFS_SLICER_FILTER |=> hrdata_out == 32'h0000_0000)
        else $error("paged register readable with page closed");
    a_reserved_nibble: assert property (carrier_count_control_r[7:4] == 4'h0) // R17
        else $error("reserved bits became set");
    a_gain_to_output: assert property ( // R2
        ##1 frontend_cfg_out.third_amp_gain == $past(deq_gain_control_r[7:6]))
        else $error("gain field not driven to front end");
    a_polarity_carrier: assert property ( // R10
        !data_mode_in |=> !decoder_cfg_out.manchester_polarity)
        else $error("polarity used in carrier mode");
    a_az_needs_enable: assert property ( // R4
        autozero_req_out |-> $past(data_mode_in) && frontend_cfg_out.data_autozero_enable)
        else $error("auto-zero outside enabled data frame");
    a_az_after_edges: assert property ( // R18
        $rose(autozero_req_out) |-> $past(az_edges_r) >= decoder_cfg_out.autozero_edge_count)
        else $error("auto-zero before programmed edge count");
    a_flag_clear_w1c: assert property ( // R19
        flag_clear && !(sample_valid_in && carrier_seen_in) |=> ##1 !carrier_detect_flag_out)
        else $error("flag not cleared by write one");
    a_write_no_wait: assert property (
        addr_take && hwrite_in && bus_state_r == lf_rx_pkg::BUS_IDLE |=> hreadyout_out)
        else $error("write data phase stretched");
    a_slicer_hysteresis_to_output: assert property ( // R7
        ##1 decoder_cfg_out.slicer_hysteresis == $past(slicer_filter_control_r[7:6]))
        else $error("hysteresis field not driven to decoder");
    a_page_closed_cc: assert property ( // R1
        wr_now && !page_on && wr_addr_r == lf_rx_pkg::OFS_CARRIER_COUNT
        |=> $stable(carrier_count_control_r))
        else $error("carrier count written with page closed");
    a_az_level_gate: assert property ( // R18
        autozero_req_out && $past(mode_r[2:1]) == lf_rx_pkg::AZ_TRIG_HIGH
        |-> $past(data_level_in))
        else $error("auto-zero fired with data low");
    a_chain_single: assert property (chain_start_out |=> !chain_start_out) // R15
        else $error("chain start longer than one cycle");

endmodule : lf_receiver_control_regs

// ---- lf_receiver_control_regs_test.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module lf_receiver_control_regs_test;
    logic                      sys_clk_in = 1'b0;
    logic                      resetn_in = 1'b0;
    logic                      hsel_in = 1'b0;
    logic [31:0]               haddr_in = 32'h0;
    logic [1:0]                htrans_in = 2'h0;
    logic                      hwrite_in = 1'b0;
    logic [31:0]               hwdata_in = 32'h0;
    logic [31:0]               hrdata_out;
    logic                      hreadyout_out;
    logic                      hresp_out;
    logic                      data_mode_in = 1'b0;
    logic                      sample_valid_in = 1'b0;
    logic                      carrier_seen_in = 1'b0;
    logic                      data_edge_in = 1'b0;
    logic                      data_level_in = 1'b0;
    lf_rx_pkg::frontend_cfg_t  frontend_cfg_out;
    lf_rx_pkg::decoder_cfg_t   decoder_cfg_out;
    logic                      carrier_detect_flag_out;
    logic                      chain_start_out;
    logic                      autozero_req_out;
    int                        err_total = 0;
    int                        check_count = 0;
    int                        cycles = 0;
    int                        chain_cnt = 0;
    int                        az_cnt = 0;

    always #2 sys_clk_in = ~sys_clk_in;

    lf_receiver_control_regs dut (.sys_clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
        .hreadyout_out, .hresp_out, .data_mode_in, .sample_valid_in, .carrier_seen_in,
        .data_edge_in, .data_level_in, .frontend_cfg_out, .decoder_cfg_out,
        .carrier_detect_flag_out, .chain_start_out, .autozero_req_out);

    // Pulse outputs last one cycle (auto-zero only with a nonzero edge count), so they are counted rather than polled
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (chain_start_out === 1'b1) chain_cnt <= chain_cnt + 1;
        if (autozero_req_out === 1'b1) az_cnt <= az_cnt + 1;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel_in   <= 1'b1;
        htrans_in <= lf_rx_pkg::HTRANS_NONSEQ;
        haddr_in  <= {24'h0, a};
        hwrite_in <= w;
        @(posedge sys_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
        htrans_in <= 2'h0;
        hsel_in   <= 1'b0;
        hwdata_in <= wd;
        @(posedge sys_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
        rd = hrdata_out;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(a, 1'b1, d, t);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] t;
        bus(a, 1'b0, 32'h0, t);
        `CHK(n, e, t)
        `CHK("resp", 1'b0, hresp_out)
    endtask : rdchk

    task automatic pulse(input logic edge_kind, input logic seen);
        if (edge_kind) data_edge_in <= 1'b1;
        else begin
            sample_valid_in <= 1'b1;
            carrier_seen_in <= seen;
        end
        @(posedge sys_clk_in);
        data_edge_in    <= 1'b0;
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask : pulse

    task automatic t_page;
        wr(lf_rx_pkg::OFS_DEQ_GAIN, 32'hFF);
        repeat (2) @(posedge sys_clk_in);
        `CHK("fe closed", 8'h00, frontend_cfg_out)
        wr(lf_rx_pkg::OFS_PAGE, 32'h1);
        rdchk(lf_rx_pkg::OFS_DEQ_GAIN, 32'h0, "deq rst");
        rdchk(lf_rx_pkg::OFS_SLICER_FILTER, 32'h0, "slicer rst");
        rdchk(8'h20, 32'h0, "unmapped");
    endtask : t_page

    task automatic t_cfg;
        wr(lf_rx_pkg::OFS_DEQ_GAIN, 32'hB5);
        repeat (2) @(posedge sys_clk_in);
        `CHK("gain", 2'h2, frontend_cfg_out.third_amp_gain)
        `CHK("fe", 8'hB5, frontend_cfg_out)
        rdchk(lf_rx_pkg::OFS_DEQ_GAIN, 32'hB5, "deq rd");
        wr(lf_rx_pkg::OFS_SLICER_FILTER, 32'hFE);
        repeat (2) @(posedge sys_clk_in);
        `CHK("dec carrier", 8'hF6, decoder_cfg_out)
        data_mode_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        `CHK("dec data", 8'hFE, decoder_cfg_out)
        data_mode_in <= 1'b0;
        wr(lf_rx_pkg::OFS_CARRIER_COUNT, 32'hF2);
        rdchk(lf_rx_pkg::OFS_CARRIER_COUNT, 32'h2, "cc rd");
    endtask : t_cfg

    task automatic t_carrier;
        int c0;
        c0 = chain_cnt;
        pulse(1'b0, 1'b1);
        `CHK("chain", c0 + 1, chain_cnt)
        pulse(1'b0, 1'b0);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b1);
        `CHK("flag early", 1'b0, carrier_detect_flag_out)
        pulse(1'b0, 1'b1);
        `CHK("flag set", 1'b1, carrier_detect_flag_out)
        pulse(1'b0, 1'b0);
        `CHK("flag sticky", 1'b1, carrier_detect_flag_out)
        wr(lf_rx_pkg::OFS_STATUS, 32'h1);
        repeat (3) @(posedge sys_clk_in);
        `CHK("flag clr", 1'b0, carrier_detect_flag_out)
    endtask : t_carrier

    task automatic t_block;
        int c0;
        c0 = chain_cnt;
        wr(lf_rx_pkg::OFS_MODE, 32'h1);
        repeat (4) pulse(1'b0, 1'b1);
        `CHK("tog flag", 1'b0, carrier_detect_flag_out)
        rdchk(lf_rx_pkg::OFS_STATUS, 32'h0, "tog count");
        wr(lf_rx_pkg::OFS_MODE, 32'h0);
        data_mode_in <= 1'b1;
        repeat (4) pulse(1'b0, 1'b1);
        `CHK("dm flag", 1'b0, carrier_detect_flag_out)
        `CHK("dm chain", c0, chain_cnt)
        data_mode_in <= 1'b0;
    endtask : t_block

    task automatic t_autozero;
        int a0;
        wr(lf_rx_pkg::OFS_DEQ_GAIN, 32'h08);
        wr(lf_rx_pkg::OFS_SLICER_FILTER, 32'h02);
        data_mode_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        a0 = az_cnt;
        pulse(1'b1, 1'b0);
        `CHK("az one edge", a0, az_cnt)
        pulse(1'b1, 1'b0);
        `CHK("az two edges", a0 + 1, az_cnt)
        wr(lf_rx_pkg::OFS_MODE, 32'h6);
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        `CHK("az data low", a0 + 1, az_cnt)
        data_level_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        `CHK("az data high", a0 + 2, az_cnt)
        data_mode_in <= 1'b0;
    endtask : t_autozero

    task automatic results;
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    initial begin
        repeat (10) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        t_page();
        t_cfg();
        t_carrier();
        t_block();
        t_autozero();
        results();
    end
endmodule : lf_receiver_control_regs_test
